// ===== bench/host_mcu_model.sv
`timescale 1ns/1ps
// ====================
// Host side of mode pins, transmit data and serial port
module host_mcu_model (
   input wire logic clk,
   input wire logic fault_n,
   output logic mode_a,
   output logic mode_b,
   output logic tx
);
   initial begin
      mode_a = 1'b0;
      mode_b = 1'b0;
      tx = 1'b1;
   end

   // ====================
   // Static mode select as {A,B}
   task automatic set_pins(input logic a, input logic b);
      @(posedge clk);
      mode_a <= a;
      mode_b <= b;
   endtask

   // ====================
   // Transmit data level and one low-high pulse
   task automatic drive_tx(input logic b);
      @(posedge clk);
      tx <= b;
   endtask

   task automatic tx_pulse();
      drive_tx(1'b0);
      drive_tx(1'b1);
   endtask

   // ====================
   // One serial frame, MSB first both ways
   task automatic frame(input logic [7:0] dout, output logic [7:0] din);
      @(posedge clk);
      mode_b <= 1'b0;
      repeat (2) @(posedge clk);
      for (int i = 7; i >= 0; i--) begin
         mode_a <= dout[i];
         mode_b <= 1'b1;
         repeat (4) @(posedge clk);
         din[i] = fault_n;
         mode_b <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask
endmodule

// ===== bench/test_can_transceiver_mode_diag.sv
`timescale 1ns/1ps
// ====================
// Comparison note macro
`define CHK(nm, e, g) begin nm_q.push_back(nm); \
   exp_q.push_back(32'(e)); got_q.push_back(32'(g)); end
module test_can_transceiver_mode_diag;
   import can_phy_pkg::*;
   localparam int HOLD = 8;
   logic sys_clk, rstn, tx, rx, mode_a, mode_b, fault_n, ext_ctl, lwake;
   logic drv, other, uv, rail, bus_fail, loc_fail, err, bat_low;
   logic [1:0] slew, prev;
   logic [1:0] sent [3] = '{2'h2, 2'h3, 2'h1};
   logic [1:0] held [3] = '{2'h2, 2'h2, 2'h1};
   logic [7:0] din;
   logic [31:0] rd, x;
   apb_req_t req;
   apb_rsp_t rsp;
   int mismatches, n_checks;
   string nm_q[$];
   logic [31:0] exp_q[$], got_q[$];

   can_transceiver_mode_diag #(.HOLD_COUNT(HOLD)) DUT (
      .SYS_CLK(sys_clk), .RSTN(rstn), .APB_REQ(req), .APB_RSP(rsp),
      .TX_DATA(tx), .RX_DATA(rx), .MODE_PIN_A(mode_a), .MODE_PIN_B(mode_b),
      .FAULT_N(fault_n), .EXT_SUPPLY_CTL(ext_ctl), .LOCAL_WAKE(lwake),
      .CAN_WAKE_SEEN(1'b0), .BUS_DRIVE_DOMINANT(drv),
      .BUS_IS_DOMINANT(drv | other), .SLEW_SEL(slew),
      .BATTERY_FEED_LOW(bat_low), .UNDERVOLT_SHUTDOWN(uv),
      .RAIL_ENABLE(rail),
      .BUS_FAILURE(bus_fail), .LOCAL_FAILURE(loc_fail));
   host_mcu_model host (.clk(sys_clk), .fault_n(fault_n), .mode_a(mode_a),
      .mode_b(mode_b), .tx(tx));

   // ====================
   // Clock, random source, bus tasks
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = !sys_clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge sys_clk);
      req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
      @(posedge sys_clk);
      req.penable <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         @(posedge sys_clk);
         if (rsp.pready === 1'b1) break;
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic summarize();
      $display("mismatches %0d checks %0d", mismatches, n_checks);
      if (mismatches == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ====================
   // Result checker and watchdog
   initial forever begin
      wait (got_q.size() > 0);
      n_checks++;
      if (got_q[0] !== exp_q[0]) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm_q[0], exp_q[0],
            got_q[0]);
      end
      void'(nm_q.pop_front());
      void'(exp_q.pop_front());
      void'(got_q.pop_front());
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      summarize();
   end

   // ====================
   // Main sequence
   initial begin
      rstn = 1'b0;
      req = '0;
      lwake = 1'b0;
      other = 1'b0;
      uv = 1'b0;
      bat_low = 1'b0;
      bus_fail = 1'b0;
      loc_fail = 1'b0;
      x = 32'h1;
      cyc(3);
      rstn <= 1'b1;
      apb(1'b0, STATUS_OFFSET, 32'h0);
      `CHK("mode", 3'h0, rd[2:0])
      `CHK("supply_loss", 1'b1, rd[ST_BATFAIL_BIT])
      host.set_pins(1'b1, 1'b0);
      cyc(HOLD + 8);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      `CHK("mode", 3'h3, rd[2:0])
      `CHK("ext", 1'b1, ext_ctl)
      apb(1'b0, 8'h10, 32'h0);
      `CHK("slverr", 1'b1, err)
      `CHK("prdata", 32'h0, rd)
      bus_fail <= 1'b1;
      host.set_pins(1'b1, 1'b1);
      cyc(2);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      `CHK("mode", 3'h1, rd[2:0])
      `CHK("supply_loss", 1'b0, rd[ST_BATFAIL_BIT])
      for (int i = 0; i < 12; i++) begin
         host.drive_tx(x[0]);
         other <= x[1];
         x = xs(x);
         cyc(3);
         `CHK("drive", !tx, drv)
         `CHK("rx", !(drv | other), rx)
      end
      repeat (4) host.tx_pulse();
      cyc(3);
      `CHK("fault", 1'b0, fault_n)
      loc_fail <= 1'b1;
      host.set_pins(1'b0, 1'b1);
      host.drive_tx(1'b0);
      cyc(3);
      `CHK("drive", 1'b0, drv)
      `CHK("fault", 1'b0, fault_n)
      bus_fail <= 1'b0;
      loc_fail <= 1'b0;
      host.drive_tx(1'b1);
      host.set_pins(1'b0, 1'b0);
      apb(1'b1, CTRL_OFFSET, 32'h1);
      prev = SLEW_RESET;
      for (int i = 0; i < 3; i++) begin
         host.frame({6'h0, sent[i]}, din);
         `CHK("sdo", {6'h0, prev}, din)
         cyc(2);
         `CHK("slew", held[i], slew)
         prev = held[i];
      end
      apb(1'b1, CTRL_OFFSET, 32'h0);
      host.set_pins(1'b1, 1'b0);
      cyc(HOLD + 8);
      `CHK("ext", 1'b0, ext_ctl)
      host.set_pins(1'b0, 1'b0);
      lwake <= 1'b1;
      cyc(4);
      `CHK("ext", 1'b1, ext_ctl)
      `CHK("rx", 1'b0, rx)
      `CHK("fault", 1'b0, fault_n)
      apb(1'b0, STATUS_OFFSET, 32'h0);
      `CHK("mode", 3'h0, rd[2:0])
      host.set_pins(1'b1, 1'b1);
      cyc(3);
      `CHK("fault", 1'b0, fault_n)
      uv <= 1'b1;
      cyc(3);
      `CHK("rail", 1'b0, rail)
      uv <= 1'b0;
      cyc(3);
      `CHK("rail", 1'b0, rail)
      bat_low <= 1'b1;
      cyc(2);
      bat_low <= 1'b0;
      cyc(3);
      `CHK("rail", 1'b1, rail)
      apb(1'b0, STATUS_OFFSET, 32'h0);
      `CHK("supply_loss", 1'b1, rd[ST_BATFAIL_BIT])
      uv <= 1'b1;
      cyc(3);
      uv <= 1'b0;
      cyc(3);
      `CHK("rail", 1'b0, rail)
      host.set_pins(1'b0, 1'b1);
      cyc(3);
      `CHK("rail", 1'b1, rail)
      wait (got_q.size() == 0);
      summarize();
   end
endmodule

// ===== rtl/can_phy_pkg.sv
package can_phy_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int HOLD_TIME_US = 50;
   localparam int HOLD_CYCLES =
      (HOLD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] TX_EDGES_BEFORE_FAULT = 3'h4;

   // ==========================================================
   // Register map
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam int CTRL_SERIAL_BIT = 0;
   localparam logic CTRL_SERIAL_RESET = 1'b0;

   // STATUS field positions
   localparam int ST_MODE_LSB = 0;
   localparam int ST_BATFAIL_BIT = 4;
   localparam int ST_WAKE_BIT = 5;
   localparam int ST_WAKE_LOCAL_BIT = 6;
   localparam int ST_RAIL_BIT = 7;
   localparam int ST_SLEW_LSB = 8;
   localparam int ST_TXCNT_LSB = 12;

   // ==========================================================
   // Serial frame
   localparam int SERIAL_WIDTH = 8;
   localparam int CMD_SLEW_LSB = 0;
   localparam logic [1:0] SLEW_RESET = 2'h0;
   localparam logic [1:0] SLEW_MAX = 2'h2;
   localparam logic BATFAIL_RESET = 1'b1;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      MODE_STANDBY,
      MODE_NORMAL,
      MODE_LISTEN,
      MODE_GOTOSLEEP,
      MODE_SLEEP
   } op_mode_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

endpackage

// ===== rtl/can_transceiver_mode_diag.sv
`timescale 1ns/1ps
// What this block does
// RULE1: TX low drives bus dominant
// RULE2: TX high leaves bus recessive
// RULE3: RX low when dominant, high when recessive
// RULE4: RX is active-low wake flag in low power
// RULE5: Three slew settings, chosen over serial port
// RULE6: Mode pin A is serial data in
// RULE7: Fault pin is serial data out
// RULE8: Mode pin B is serial clock
// RULE9: Both sides shift at serial clock rise
// RULE10: Supply control low requests external shutdown
// RULE11: Fault pin active low, content follows mode
// RULE12: Local wake edge of either sense wakes
// RULE13: Sleep only with supply-loss and wake cleared
// RULE14: Supply control high signals wake in sleep
// RULE15: Wake source shown until fourth TX rise
// RULE16: Rail back on battery recovery or mode change
// RULE17: Pins high enter normal, clear supply-loss
// RULE18: Pins low-high give listen-only, no drive
// RULE19: Pins high-low go-to-sleep, sleep after hold
// RULE20: Standby first after power-up
// RULE21: Both pins low enter standby
module can_transceiver_mode_diag
   import can_phy_pkg::*;
#(
   parameter int HOLD_COUNT = HOLD_CYCLES
) (
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input can_phy_pkg::apb_req_t APB_REQ,
   output can_phy_pkg::apb_rsp_t APB_RSP,
   input wire logic TX_DATA,
   output logic RX_DATA,
   input wire logic MODE_PIN_A,
   input wire logic MODE_PIN_B,
   output logic FAULT_N,
   output logic EXT_SUPPLY_CTL,
   input wire logic LOCAL_WAKE,
   input wire logic CAN_WAKE_SEEN,
   output logic BUS_DRIVE_DOMINANT,
   input wire logic BUS_IS_DOMINANT,
   output logic [1:0] SLEW_SEL,
   input wire logic BATTERY_FEED_LOW,
   input wire logic UNDERVOLT_SHUTDOWN,
   output logic RAIL_ENABLE,
   input wire logic BUS_FAILURE,
   input wire logic LOCAL_FAILURE
);
   import can_phy_pkg::*;

   localparam int HW = $clog2(HOLD_COUNT + 1);

   // ==========================================================
   // State
   op_mode_t mode_reg, mode_next;
   logic from_normal_reg;
   logic serial_en_reg;
   logic [1:0] slew_reg;
   logic batfail_reg;
   logic wake_reg;
   logic wake_local_reg;
   logic [2:0] txcnt_reg;
   logic [HW-1:0] hold_reg;
   logic rail_reg;
   logic tx_prev_reg, wake_prev_reg, sclk_prev_reg, batlow_prev_reg;
   logic [1:0] pins_prev_reg;
   logic started_reg;
   logic rx_reg, fault_reg, ext_reg, drive_reg;

   // ==========================================================
   // Pin decoding
   wire [1:0] pins = {MODE_PIN_A, MODE_PIN_B};
   wire static_ctl = !serial_en_reg;
   wire sclk_rise = serial_en_reg && MODE_PIN_B && !sclk_prev_reg; // [RULE8]
   wire tx_rise = TX_DATA && !tx_prev_reg;
   wire local_edge = started_reg && (LOCAL_WAKE != wake_prev_reg); // [RULE12]
   wire pins_changed = started_reg && (pins != pins_prev_reg);
   wire bat_recover = batlow_prev_reg && !BATTERY_FEED_LOW;
   wire low_power = (mode_reg == MODE_STANDBY) ||
      (mode_reg == MODE_GOTOSLEEP) || (mode_reg == MODE_SLEEP);
   wire local_wake_ok = low_power && local_edge;
   wire can_wake_ok = CAN_WAKE_SEEN &&
      ((mode_reg == MODE_STANDBY) || (mode_reg == MODE_SLEEP));
   wire flags_clear = !batfail_reg && !wake_reg;
   wire hold_done = (hold_reg == HW'(HOLD_COUNT));
   wire leave_normal = (mode_reg == MODE_NORMAL) &&
      (mode_next != MODE_NORMAL);
   wire enter_normal = (mode_reg != MODE_NORMAL) &&
      (mode_next == MODE_NORMAL);
   wire src_phase = (txcnt_reg < TX_EDGES_BEFORE_FAULT);

   // ==========================================================
   // Serial port
   logic serial_out, serial_done;
   logic [SERIAL_WIDTH-1:0] serial_cmd;
   wire [SERIAL_WIDTH-1:0] serial_status = {1'b0, LOCAL_FAILURE,
      BUS_FAILURE, wake_local_reg, wake_reg, batfail_reg, slew_reg};
   wire [1:0] cmd_slew = serial_cmd[CMD_SLEW_LSB +: 2];

   pseudo_serial_port #(
      .WIDTH(SERIAL_WIDTH)
   ) u_serial (
      .clk(SYS_CLK),
      .rstn(RSTN),
      .enable(serial_en_reg),
      .sclk_rise(sclk_rise), // [RULE9]
      .sdi(MODE_PIN_A), // [RULE6]
      .load_data(serial_status),
      .sdo(serial_out),
      .frame_done(serial_done),
      .rx_word(serial_cmd)
   );

   // ==========================================================
   // Mode sequencing
   always_comb begin
      mode_next = mode_reg;
      if (mode_reg == MODE_SLEEP) begin
         if (local_wake_ok || can_wake_ok)
            mode_next = MODE_STANDBY;
      end else if (static_ctl) begin
         unique case (pins)
            2'b11: mode_next = MODE_NORMAL; // [RULE17]
            2'b01: mode_next = MODE_LISTEN; // [RULE18]
            2'b00: mode_next = MODE_STANDBY; // [RULE21]
            2'b10: begin
               mode_next = MODE_GOTOSLEEP; // [RULE19]
               if (mode_reg == MODE_GOTOSLEEP && hold_done && flags_clear)
                  mode_next = MODE_SLEEP; // [RULE13]
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         mode_reg <= MODE_STANDBY; // [RULE20]
         from_normal_reg <= 1'b0;
         hold_reg <= '0;
      end else begin
         mode_reg <= mode_next;
         if (mode_next == MODE_LISTEN && mode_reg != MODE_LISTEN)
            from_normal_reg <= (mode_reg == MODE_NORMAL);
         if (mode_reg == MODE_GOTOSLEEP && mode_next == MODE_GOTOSLEEP)
            hold_reg <= hold_done ? hold_reg : hold_reg + 1'b1; // [RULE19]
         else
            hold_reg <= '0;
      end
   end

   // ==========================================================
   // Flags
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         batfail_reg <= BATFAIL_RESET;
         wake_reg <= 1'b0;
         wake_local_reg <= 1'b0;
         slew_reg <= SLEW_RESET;
         txcnt_reg <= '0;
      end else begin
         if (BATTERY_FEED_LOW)
            batfail_reg <= 1'b1;
         else if (enter_normal)
            batfail_reg <= 1'b0; // [RULE17]
         if (local_wake_ok || can_wake_ok) begin
            wake_reg <= 1'b1;
            wake_local_reg <= local_wake_ok;
         end else if (leave_normal || serial_done) begin
            wake_reg <= 1'b0;
         end
         if (serial_done && cmd_slew <= SLEW_MAX)
            slew_reg <= cmd_slew; // [RULE5]
         if (enter_normal)
            txcnt_reg <= '0;
         else if (mode_reg == MODE_NORMAL && tx_rise && src_phase)
            txcnt_reg <= txcnt_reg + 1'b1; // [RULE15]
      end
   end

   // ==========================================================
   // Rail and edge history
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rail_reg <= 1'b1;
         tx_prev_reg <= 1'b1;
         wake_prev_reg <= 1'b0;
         sclk_prev_reg <= 1'b0;
         batlow_prev_reg <= 1'b0;
         pins_prev_reg <= 2'h0;
         started_reg <= 1'b0;
      end else begin
         if (UNDERVOLT_SHUTDOWN)
            rail_reg <= 1'b0;
         else if (bat_recover || (static_ctl && pins_changed))
            rail_reg <= 1'b1; // [RULE16]
         tx_prev_reg <= TX_DATA;
         wake_prev_reg <= LOCAL_WAKE;
         sclk_prev_reg <= MODE_PIN_B;
         batlow_prev_reg <= BATTERY_FEED_LOW;
         pins_prev_reg <= pins;
         started_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Pin outputs
   logic fault_next;
   always_comb begin
      fault_next = 1'b1;
      unique case (mode_reg)
         MODE_NORMAL:
            fault_next = src_phase ? !wake_local_reg : !BUS_FAILURE;
         MODE_LISTEN:
            fault_next = from_normal_reg ? !LOCAL_FAILURE : !batfail_reg;
         MODE_STANDBY, MODE_GOTOSLEEP, MODE_SLEEP:
            fault_next = !wake_reg;
      endcase
   end

   wire drive_next = (mode_reg == MODE_NORMAL) && !TX_DATA; // [RULE1] [RULE2]
   wire rx_next = low_power ? !wake_reg : !BUS_IS_DOMINANT; // [RULE3] [RULE4]
   wire ext_next = (mode_reg != MODE_SLEEP) || wake_reg; // [RULE10] [RULE14]

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         drive_reg <= 1'b0;
         rx_reg <= 1'b1;
         fault_reg <= 1'b1;
         ext_reg <= 1'b1;
      end else begin
         drive_reg <= drive_next;
         rx_reg <= rx_next;
         fault_reg <= serial_en_reg ? serial_out : fault_next; // [RULE7] [RULE11]
         ext_reg <= ext_next;
      end
   end

   assign BUS_DRIVE_DOMINANT = drive_reg;
   assign RX_DATA = rx_reg;
   assign FAULT_N = fault_reg;
   assign EXT_SUPPLY_CTL = ext_reg;
   assign SLEW_SEL = slew_reg;
   assign RAIL_ENABLE = rail_reg;

   // ==========================================================
   // APB slave, zero wait states
   wire sel_ctrl = APB_REQ.paddr == CTRL_OFFSET;
   wire sel_status = APB_REQ.paddr == STATUS_OFFSET;
   wire mapped = sel_ctrl || sel_status;
   wire access = APB_REQ.psel && APB_REQ.penable;
   wire ctrl_wr = access && APB_REQ.pwrite && sel_ctrl;
   wire [31:0] ctrl_word = {31'h0, serial_en_reg};
   wire [31:0] status_word = {17'h0, txcnt_reg, 2'h0, slew_reg,
      rail_reg, wake_local_reg, wake_reg, batfail_reg, 1'b0, mode_reg};
   wire [31:0] read_word = sel_ctrl ? ctrl_word :
      sel_status ? status_word : 32'h0;

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN)
         serial_en_reg <= CTRL_SERIAL_RESET;
      else if (ctrl_wr)
         serial_en_reg <= APB_REQ.pwdata[CTRL_SERIAL_BIT];
   end

   assign APB_RSP.pready = 1'b1;
   assign APB_RSP.pslverr = access && !mapped;
   assign APB_RSP.prdata = (access && !APB_REQ.pwrite) ? read_word : 32'h0;

   // ==========================================================
   // Checks
   AST_DRIVE_DOM: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (mode_reg == MODE_NORMAL && !TX_DATA) |=> BUS_DRIVE_DOMINANT) // [RULE1]
      else $error("bus not dominant for tx low");
   AST_DRIVE_REC: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      TX_DATA |=> !BUS_DRIVE_DOMINANT) // [RULE2]
      else $error("bus driven for tx high");
   AST_RX_FOLLOW: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (mode_reg == MODE_NORMAL) |=> (RX_DATA == !$past(BUS_IS_DOMINANT))) // [RULE3]
      else $error("rx does not follow bus");
   AST_RX_WAKE: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (mode_reg == MODE_STANDBY && wake_reg) |=> !RX_DATA) // [RULE4]
      else $error("rx misses wake flag");
   AST_SLEW_RANGE: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      SLEW_SEL <= SLEW_MAX) // [RULE5]
      else $error("illegal slew setting");
   AST_SERIAL_OUT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      serial_en_reg |=> (FAULT_N == $past(serial_out))) // [RULE7]
      else $error("fault pin not serial data");
   AST_SUPPLY_SLEEP: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (mode_reg == MODE_SLEEP && !wake_reg) |=> !EXT_SUPPLY_CTL) // [RULE10]
      else $error("supply not released in sleep");
   AST_SLEEP_GATE: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (mode_reg == MODE_GOTOSLEEP && (batfail_reg || wake_reg))
      |=> mode_reg != MODE_SLEEP) // [RULE13]
      else $error("sleep entered with flags set");
   AST_WAKE_EXIT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (mode_reg == MODE_SLEEP && local_edge) |=> mode_reg == MODE_STANDBY) // [RULE12]
      else $error("local wake ignored in sleep");
   AST_NORMAL_CLR: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (enter_normal && !BATTERY_FEED_LOW) |=> !batfail_reg ##1 
      (txcnt_reg == 3'h0 || mode_reg != MODE_NORMAL || tx_prev_reg)) // [RULE17]
      else $error("normal entry did not clear supply loss");
   AST_TX_CNT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      txcnt_reg <= TX_EDGES_BEFORE_FAULT) // [RULE15]
      else $error("tx edge count overrun");
   AST_LISTEN_NODRV: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (mode_reg == MODE_LISTEN) |=> !BUS_DRIVE_DOMINANT) // [RULE18]
      else $error("bus driven in listen only");

   COV_SLEEP: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      mode_reg == MODE_GOTOSLEEP ##1 mode_reg == MODE_SLEEP);
   COV_WAKE: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      mode_reg == MODE_SLEEP ##1 mode_reg == MODE_STANDBY);
   COV_FRAME: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      serial_done);
   COV_FAULT_PHASE: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      mode_reg == MODE_NORMAL && txcnt_reg == TX_EDGES_BEFORE_FAULT);
endmodule

// ===== rtl/pseudo_serial_port.sv
`timescale 1ns/1ps
module pseudo_serial_port #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic enable,
   input wire logic sclk_rise,
   input wire logic sdi,
   input wire logic [WIDTH-1:0] load_data,
   output logic sdo,
   output logic frame_done,
   output logic [WIDTH-1:0] rx_word
);
   localparam int CW = $clog2(WIDTH);
   localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

   logic [CW-1:0] cnt_reg;
   logic [WIDTH-1:0] tx_reg;
   logic [WIDTH-1:0] rx_reg;
   logic done_reg;
   wire first_bit = (cnt_reg == '0);
   wire last_bit = (cnt_reg == LAST);

   // ==========================================================
   // Shift on each serial clock rising edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= '0;
         tx_reg <= '0;
         rx_reg <= '0;
         done_reg <= 1'b0;
      end else if (!enable) begin
         cnt_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= sclk_rise && last_bit;
         if (sclk_rise) begin
            rx_reg <= {rx_reg[WIDTH-2:0], sdi};
            tx_reg <= first_bit ? load_data : {tx_reg[WIDTH-2:0], 1'b0};
            cnt_reg <= last_bit ? '0 : cnt_reg + 1'b1;
         end
      end
   end

   assign sdo = tx_reg[WIDTH-1];
   assign frame_done = done_reg;
   assign rx_word = rx_reg;
endmodule
